/* include/sbsr_pkg.sv */
// Package for the status byte and service request block
package sbsr_pkg;
  // Status byte bit positions
  localparam int BIT_B0   = 0;
  localparam int BIT_EAV  = 2;
  localparam int BIT_QSB  = 3;
  localparam int BIT_MAV  = 4;
  localparam int BIT_ESB  = 5;
  localparam int BIT_B6   = 6;
  localparam int BIT_OSB  = 7;
  // Summary bits that feed bit B6 (B0,B2,B3,B4,B5,B7)
  localparam logic [7:0] SUMMARY_MASK = 8'h0000_00BD;
  // Reset values
  localparam logic [7:0] SRE_RESET    = 8'h0000_0000;
  localparam logic [7:0] EVENT_RESET  = 8'h0000_0000;
  // Error and output queue depths
  localparam int ERR_DEPTH_DEF = 10;
  localparam int OUT_DEPTH_DEF = 4;

  // Queue push request
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } sbsr_msg_t;

  // Per event register set: condition bits and enable
  typedef struct packed {
    logic [7:0] cond;
    logic [7:0] enable;
  } sbsr_evset_t;
endpackage

/* src/sbsr_top.sv */
// Status byte, queues and service request logic of the device
// What this block does
// [RULE1] Keep output queue and error queue, FIFO order
// [RULE2] Query response goes into output queue
// [RULE3] Output queue write sets message ready
// [RULE4] Read removes; empty output queue clears ready
// [RULE5] Events enqueue to error queue, ten deep
// [RULE6] Error queue entry sets error pending
// [RULE7] Read removes; empty error queue clears pending
// [RULE8] Host queries error then addresses talk
// [RULE9] Summary bits follow their messages, no latch
// [RULE10] Reading standard event register clears its summary
// [RULE11] Status query B6 shows master summary
// [RULE12] Status query changes no status bits
// [RULE13] Enabled summary rising sets request and SRQ
// [RULE14] Serial poll returns request flag, then clears
// [RULE15] After poll same event may request again
// [RULE16] Master summary holds until summaries clear
// [RULE17] Clear command clears status bits, queues
// [RULE18] Enable mask ANDs summaries, ORed into B6
// [RULE19] Enable mask written and read back
// [RULE20] Enable mask clears on reset or zero write
// [RULE21] Event registers latch condition, summary AND/OR
// [RULE22] Event read or clear command clears event
// [RULE23] Full error queue drops new messages
// [RULE24] Flags update with the queue change
module sbsr_top
  import sbsr_pkg::*;
#(
  parameter int ERR_DEPTH = ERR_DEPTH_DEF,
  parameter int OUT_DEPTH = OUT_DEPTH_DEF
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire sbsr_msg_t   OUT_PUSH_I,
  input  wire logic        OUT_POP_I,
  input  wire sbsr_msg_t   ERR_PUSH_I,
  input  wire logic        ERR_POP_I,
  input  wire sbsr_evset_t STD_EV_I,
  input  wire sbsr_evset_t QUES_EV_I,
  input  wire sbsr_evset_t OPER_EV_I,
  input  wire logic        STD_EV_READ_I,
  input  wire logic        QUES_EV_READ_I,
  input  wire logic        OPER_EV_READ_I,
  input  wire logic        B0_SUMMARY_I,
  input  wire logic        CLS_I,
  input  wire logic        SRE_WR_I,
  input  wire logic [7:0]  SRE_DATA_I,
  input  wire logic        SERIAL_POLL_I,
  output logic [15:0]      OUT_DATA_O,
  output logic             OUT_EMPTY_O,
  output logic             OUT_FULL_O,
  output logic [15:0]      ERR_DATA_O,
  output logic             ERR_EMPTY_O,
  output logic             ERR_FULL_O,
  output logic [7:0]       STB_QUERY_O,
  output logic [7:0]       STB_POLL_O,
  output logic [7:0]       SRE_O,
  output logic [7:0]       STD_EVENT_O,
  output logic             SRQ_O
);
  localparam int OW = $clog2(OUT_DEPTH + 1);
  localparam int EW = $clog2(ERR_DEPTH + 1);

  // Queue storage, shift-out style so head is always slot 0
  logic [OUT_DEPTH-1:0][15:0] oq_r, oq_nxt;
  logic [ERR_DEPTH-1:0][15:0] eq_r, eq_nxt;
  logic [OW-1:0]              ocnt_r, ocnt_nxt;
  logic [EW-1:0]              ecnt_r, ecnt_nxt;
  logic [7:0] std_ev_r, std_ev_nxt, ques_ev_r, ques_ev_nxt;
  logic [7:0] oper_ev_r, oper_ev_nxt;
  logic [7:0] sre_r, sre_nxt;
  logic [7:0] summ_r, summ_nxt;
  logic       rqs_r, rqs_nxt;
  logic       mss_r, mss_nxt;
  logic       srq_r, srq_nxt;
  logic [7:0] stbq_r, stbq_nxt, stbp_r, stbp_nxt;
  logic [7:0] std_o_r, std_o_nxt;

  // Output queue: pop then push, full queue refuses push
  always_comb begin
    logic [OW-1:0] c;
    c = ocnt_r;
    oq_nxt = oq_r;
    if (CLS_I) begin
      c = '0;
    end else begin
      if (OUT_POP_I && c != '0) begin // see [RULE4]
        for (int i = 0; i < OUT_DEPTH - 1; i++) begin
          oq_nxt[i] = oq_nxt[i+1];
        end
        c = c - OW'(1);
      end
      if (OUT_PUSH_I.valid && c != OW'(OUT_DEPTH)) begin // see [RULE2]
        oq_nxt[c] = OUT_PUSH_I.data; // see [RULE1]
        c = c + OW'(1);
      end
    end
    ocnt_nxt = c;
  end

  // Error queue: when full, new messages dropped, old kept
  always_comb begin
    logic [EW-1:0] c;
    c = ecnt_r;
    eq_nxt = eq_r;
    if (CLS_I) begin
      c = '0;
    end else begin
      if (ERR_POP_I && c != '0) begin // see [RULE7]
        for (int i = 0; i < ERR_DEPTH - 1; i++) begin
          eq_nxt[i] = eq_nxt[i+1];
        end
        c = c - EW'(1);
      end
      if (ERR_PUSH_I.valid && c != EW'(ERR_DEPTH)) begin // see [RULE23]
        eq_nxt[c] = ERR_PUSH_I.data; // see [RULE5]
        c = c + EW'(1);
      end
    end
    ecnt_nxt = c;
  end

  // Event registers latch conditions; read or clear wins,
  // but a condition present in the same cycle stays set
  always_comb begin
    std_ev_nxt  = (STD_EV_READ_I || CLS_I) ? EVENT_RESET : std_ev_r;
    ques_ev_nxt = (QUES_EV_READ_I || CLS_I) ? EVENT_RESET : ques_ev_r;
    oper_ev_nxt = (OPER_EV_READ_I || CLS_I) ? EVENT_RESET : oper_ev_r;
    std_ev_nxt  = std_ev_nxt | STD_EV_I.cond; // see [RULE21]
    ques_ev_nxt = ques_ev_nxt | QUES_EV_I.cond;
    oper_ev_nxt = oper_ev_nxt | OPER_EV_I.cond; // see [RULE22]
    std_o_nxt   = std_ev_r;
  end

  // Enable mask: stores data ANDed with SUMMARY_MASK, zero write clears it
  always_comb begin
    sre_nxt = sre_r;
    if (SRE_WR_I) begin
      sre_nxt = SRE_DATA_I & SUMMARY_MASK; // see [RULE19] [RULE20]
    end
  end

  // Summary bits follow sources in the same cycle as queue change
  always_comb begin
    summ_nxt = '0;
    summ_nxt[BIT_B0]  = B0_SUMMARY_I & ~CLS_I;
    summ_nxt[BIT_EAV] = (ecnt_nxt != '0); // see [RULE6] [RULE24]
    summ_nxt[BIT_MAV] = (ocnt_nxt != '0); // see [RULE3] [RULE24]
    summ_nxt[BIT_QSB] = |(ques_ev_nxt & QUES_EV_I.enable); // see [RULE9]
    summ_nxt[BIT_ESB] = |(std_ev_nxt & STD_EV_I.enable); // see [RULE10]
    summ_nxt[BIT_OSB] = |(oper_ev_nxt & OPER_EV_I.enable);
  end

  // Master summary, request flag and SRQ line
  always_comb begin
    logic [7:0] en_now;
    logic [7:0] rise;
    en_now  = summ_nxt & sre_nxt & SUMMARY_MASK; // see [RULE18]
    rise    = en_now & ~(summ_r & sre_r);
    mss_nxt = |en_now; // see [RULE16]
    rqs_nxt = rqs_r;
    if (SERIAL_POLL_I || CLS_I) begin
      rqs_nxt = 1'b0; // see [RULE14]
    end
    if (|rise) begin
      rqs_nxt = 1'b1; // see [RULE13] [RULE15]
    end
    srq_nxt = rqs_nxt;
    stbq_nxt = summ_nxt;
    stbq_nxt[BIT_B6] = mss_nxt; // see [RULE11] [RULE12]
    stbp_nxt = summ_r;
    stbp_nxt[BIT_B6] = rqs_r;
  end

  // Register stage; CLS clears status through the next values
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin // see [RULE17]
      oq_r      <= '0;
      eq_r      <= '0;
      ocnt_r    <= '0;
      ecnt_r    <= '0;
      std_ev_r  <= EVENT_RESET;
      ques_ev_r <= EVENT_RESET;
      oper_ev_r <= EVENT_RESET;
      sre_r     <= SRE_RESET;
      summ_r    <= '0;
      rqs_r     <= 1'b0;
      mss_r     <= 1'b0;
      srq_r     <= 1'b0;
      stbq_r    <= '0;
      stbp_r    <= '0;
      std_o_r   <= '0;
    end else begin
      oq_r      <= oq_nxt;
      eq_r      <= eq_nxt;
      ocnt_r    <= ocnt_nxt;
      ecnt_r    <= ecnt_nxt;
      std_ev_r  <= std_ev_nxt;
      ques_ev_r <= ques_ev_nxt;
      oper_ev_r <= oper_ev_nxt;
      sre_r     <= sre_nxt;
      summ_r    <= summ_nxt;
      rqs_r     <= rqs_nxt;
      mss_r     <= mss_nxt;
      srq_r     <= srq_nxt;
      stbq_r    <= stbq_nxt;
      stbp_r    <= stbp_nxt;
      std_o_r   <= std_o_nxt;
    end
  end

  // Outputs straight from flip-flops; empty and full flags decoded from the counts
  assign OUT_DATA_O  = oq_r[0];
  assign OUT_EMPTY_O = (ocnt_r == '0);
  assign OUT_FULL_O  = (ocnt_r == OW'(OUT_DEPTH));
  assign ERR_DATA_O  = eq_r[0];
  assign ERR_EMPTY_O = (ecnt_r == '0);
  assign ERR_FULL_O  = (ecnt_r == EW'(ERR_DEPTH));
  assign STB_QUERY_O = stbq_r;
  assign STB_POLL_O  = stbp_r;
  assign SRE_O       = sre_r;
  assign STD_EVENT_O = std_o_r;
  assign SRQ_O       = srq_r;

  // Checks on the status byte and queues
  mav_tracks_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    stbq_r[BIT_MAV] == (ocnt_r != '0)) // see [RULE4]
    else $error("message ready flag disagrees with queue");
  eav_tracks_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    stbq_r[BIT_EAV] == (ecnt_r != '0)) // see [RULE7]
    else $error("error pending flag disagrees with queue");
  err_cap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ecnt_r <= EW'(ERR_DEPTH)) // see [RULE5]
    else $error("error queue over capacity");
  full_drop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ecnt_r == EW'(ERR_DEPTH) && !ERR_POP_I && !CLS_I) |=>
    $stable(eq_r)) // see [RULE23]
    else $error("full error queue changed");
  mss_or_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    stbq_r[BIT_B6] == |(stbq_r & sre_r & SUMMARY_MASK)) // see [RULE18]
    else $error("master summary not OR of enabled bits");
  poll_clr_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (SERIAL_POLL_I && !(|(summ_nxt & sre_nxt & ~(summ_r & sre_r)))) |=>
    !srq_r) // see [RULE14]
    else $error("serial poll did not clear request");
  srq_rise_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (|(summ_nxt & sre_nxt & SUMMARY_MASK & ~(summ_r & sre_r))) |=>
    srq_r && stbq_r[BIT_B6]) // see [RULE13]
    else $error("enabled rise did not request service");
  sre_store_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    SRE_WR_I |=> SRE_O == $past(SRE_DATA_I & SUMMARY_MASK)) // see [RULE19]
    else $error("enable mask not stored");
  cls_clear_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (CLS_I && !OUT_PUSH_I.valid) |=> ##1 (stbp_r[BIT_B6] == 1'b0)) // see [RULE17]
    else $error("clear left request flag set");
endmodule // sbsr_top

/* tb/sbsr_host.sv */
// Host controller model: reads, mask writes, polls, clears
module sbsr_host (
  input  wire logic       clk_i,
  output logic            out_pop_o,
  output logic            err_pop_o,
  output logic            sre_wr_o,
  output logic            poll_o,
  output logic            cls_o,
  output logic [7:0]      sre_d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] req_r = 5'h00;
  // Kinds: 0 output read, 1 error read, 2 mask write, 3 poll, 4 clear
  assign {cls_o, poll_o, sre_wr_o, err_pop_o, out_pop_o} = req_r;
  initial sre_d_o = 8'h00;
  // One request per call, held one edge; then waits two falling edges
  task automatic req(input int k, input logic [7:0] d);
    @(posedge clk_i);
    req_r <= 5'h01 << k;
    sre_d_o <= d;
    @(posedge clk_i);
    req_r <= 5'h00;
    repeat (2) @(negedge clk_i);
  endtask
endmodule // sbsr_host

/* tb/tb_top.sv */
// Self-checking bench for the status byte block
module tb_top import sbsr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, b0, std_rd;
  sbsr_msg_t   op, ep;
  sbsr_evset_t sev, qev;
  logic        qrd;
  logic        o_pop, e_pop, poll, sre_wr, cls, oe, of, ee, ef, srq;
  logic [7:0]  sre_d, stb, stbp, sre, sevo;
  logic [15:0] od, ed;
  int          miscompares = 0;
  int          cmp_count = 0;
  sbsr_top #(.ERR_DEPTH(10), .OUT_DEPTH(4)) dut (
    .CLK_I(clk), .RST_N_I(rst_n), .OUT_PUSH_I(op), .OUT_POP_I(o_pop),
    .ERR_PUSH_I(ep), .ERR_POP_I(e_pop), .STD_EV_I(sev),
    .QUES_EV_I(qev), .OPER_EV_I(16'h0000), .STD_EV_READ_I(std_rd),
    .QUES_EV_READ_I(qrd), .OPER_EV_READ_I(1'h0), .B0_SUMMARY_I(b0),
    .CLS_I(cls), .SRE_WR_I(sre_wr), .SRE_DATA_I(sre_d),
    .SERIAL_POLL_I(poll), .OUT_DATA_O(od), .OUT_EMPTY_O(oe),
    .OUT_FULL_O(of), .ERR_DATA_O(ed), .ERR_EMPTY_O(ee), .ERR_FULL_O(ef),
    .STB_QUERY_O(stb), .STB_POLL_O(stbp), .SRE_O(sre),
    .STD_EVENT_O(sevo), .SRQ_O(srq));
  sbsr_host host (.clk_i(clk), .out_pop_o(o_pop), .err_pop_o(e_pop),
    .sre_wr_o(sre_wr), .poll_o(poll), .cls_o(cls), .sre_d_o(sre_d));
  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Compare with case inequality so an unknown never matches
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One push pulse; waits so results have landed
  task automatic push(input logic err, input logic [15:0] d);
    @(posedge clk);
    if (err) ep <= '{1'h1, d};
    else op <= '{1'h1, d};
    @(posedge clk);
    ep.valid <= 1'h0;
    op.valid <= 1'h0;
    repeat (2) @(negedge clk);
  endtask
  // Overfill error queue: the eleventh word must not displace the first
  task automatic t_err();
    for (int i = 0; i < 11; i++) push(1'h1, 16'h0100 + 16'(i));
    chk(ef, 1'h1);
    chk(stb[2], 1'h1);
    for (int i = 0; i < 10; i++) begin
      chk(ed, 16'h0100 + 16'(i));
      host.req(1, 8'h00);
    end
    chk({ee, stb[2]}, 2'h2);
  endtask
  task automatic t_out();
    push(1'h0, 16'hA5A5);
    chk(stb[4], 1'h1);
    push(1'h0, 16'h5A5A);
    chk(od, 16'hA5A5);
    host.req(0, 8'h00);
    chk({od, stb[4]}, 17'h0B4B5);
    host.req(0, 8'h00);
    chk({oe, stb[4]}, 2'h2);
    // Fill the output queue to its depth
    for (int i = 0; i < 4; i++) push(1'h0, 16'h0400 + 16'(i));
    chk(of, 1'h1);
  endtask
  // Mask, request, poll and re-request of the same event
  task automatic t_srq();
    host.req(2, 8'hFF);
    chk(sre, 8'hBD);
    host.req(2, 8'h04);
    push(1'h1, 16'h0200);
    chk({srq, stbp[6]}, 2'h3);
    host.req(3, 8'h00);
    chk({srq, stb[6]}, 2'h1);
    host.req(2, 8'h00);
    chk({sre, stb[6]}, 9'h000);
    host.req(2, 8'h04);
    chk({srq, stb[6]}, 2'h3);
    host.req(3, 8'h00);
    host.req(1, 8'h00);
    chk(stb[6], 1'h0);
  endtask
  // Latched standard event, cleared by its read
  task automatic t_std();
    @(posedge clk) sev <= '{8'h20, 8'h20};
    @(posedge clk) sev.cond <= 8'h00;
    repeat (3) @(negedge clk);
    chk({sevo, stb[5]}, 9'h041);
    @(posedge clk) std_rd <= 1'h1;
    @(posedge clk) std_rd <= 1'h0;
    repeat (2) @(negedge clk);
    chk(stb[5], 1'h0);
    // Questionable set: latch, summary on B3, read clears
    @(posedge clk) qev <= '{8'h01, 8'h01};
    @(posedge clk) qev.cond <= 8'h00;
    repeat (2) @(negedge clk);
    chk(stb[3], 1'h1);
    @(posedge clk) qrd <= 1'h1;
    @(posedge clk) qrd <= 1'h0;
    repeat (2) @(negedge clk);
    chk(stb[3], 1'h0);
  endtask
  // Level summary on B0, then clear command with both queues loaded
  task automatic t_cls();
    host.req(2, 8'h01);
    @(posedge clk) b0 <= 1'h1;
    repeat (3) @(negedge clk);
    chk({stb[0], stb[6], srq}, 3'h7);
    @(posedge clk) b0 <= 1'h0;
    repeat (3) @(negedge clk);
    chk({stb[0], stb[6]}, 2'h0);
    push(1'h1, 16'h0300);
    push(1'h0, 16'h0301);
    host.req(4, 8'h00);
    chk({stb, ee, oe, srq}, 11'h006);
  endtask
  // Reset, scenarios, verdict
  initial begin
    rst_n = 1'h0;
    b0 = 1'h0;
    std_rd = 1'h0;
    op = '0;
    ep = '0;
    sev = '0;
    qev = '0;
    qrd = 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(negedge clk);
    chk({stb, sre, srq}, 17'h00000);
    t_err();
    t_out();
    t_srq();
    t_std();
    t_cls();
    end_sim();
  end
  // Hang guard: all scenarios need well under 1000 cycles
  initial begin
    #20us;
    miscompares++;
    end_sim();
  end
endmodule // tb_top
